// File: tts_pkg.sv
// Package of constants and types for the telemetry time stamper
package tts_pkg;

    // Time value: days, hours, minutes, seconds, milliseconds, microseconds
    localparam int TTS_TIME_W   = 48;
    localparam int TTS_US_W     = 10;
    localparam int TTS_MS_W     = 10;
    localparam int TTS_SEC_W    = 6;
    localparam int TTS_MIN_W    = 6;
    localparam int TTS_HR_W     = 5;
    localparam int TTS_DAY_W    = 9;

    // Field positions inside the packed time word
    localparam int TTS_US_LSB   = 0;
    localparam int TTS_MS_LSB   = 10;
    localparam int TTS_SEC_LSB  = 20;
    localparam int TTS_MIN_LSB  = 26;
    localparam int TTS_HR_LSB   = 32;
    localparam int TTS_DAY_LSB  = 37;

    // Field limits
    localparam logic [9:0] TTS_US_MAX  = 10'h3E7;
    localparam logic [9:0] TTS_MS_MAX  = 10'h3E7;
    localparam logic [5:0] TTS_SEC_MAX = 6'h3B;
    localparam logic [5:0] TTS_MIN_MAX = 6'h3B;
    localparam logic [4:0] TTS_HR_MAX  = 5'h17;
    localparam logic [8:0] TTS_DAY_MAX = 9'h16D;
    localparam logic [8:0] TTS_DAY_MIN = 9'h001;

    // Timing: one microsecond tick derived from the 86.0 MHz oscillator
    localparam int TTS_OSC_KHZ      = 86000;
    localparam int TTS_TICK_NS      = 1000;
    localparam int TTS_TICK_CYC     = (TTS_OSC_KHZ * TTS_TICK_NS) / 1000000;
    localparam int TTS_DIV_W        = 7;
    localparam logic [6:0] TTS_DIV_LAST = 7'(TTS_TICK_CYC - 1);

    // Header words written per packet
    localparam int TTS_HDR_WORDS    = 3;
    localparam int TTS_HDR_W        = 16;

    // Time source selection
    typedef enum logic {
        TTS_SRC_HOST = 1'b0,
        TTS_SRC_CODE = 1'b1
    } tts_src_t;

    // Time-code formats
    typedef enum logic [1:0] {
        TTS_FMT_A    = 2'h0,
        TTS_FMT_B    = 2'h1,
        TTS_FMT_G    = 2'h2,
        TTS_FMT_N36  = 2'h3
    } tts_fmt_t;

    // Header writer states
    typedef enum logic [1:0] {
        TTS_HDR_IDLE,
        TTS_HDR_SEND,
        TTS_HDR_DONE
    } tts_hdr_st_t;

endpackage

// File: tts_time_count.sv
// Calendar time counter advancing one microsecond per tick
`timescale 1ns/10ps
module tts_time_count
    import tts_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk_sys_i,
    input  wire logic                  rst_i,
    // Control
    input  wire logic                  load_i,
    input  wire logic [TTS_TIME_W-1:0] load_val_i,
    input  wire logic                  tick_i,
    // Time
    output logic      [TTS_TIME_W-1:0] time_o
);

    typedef struct packed {
        logic [TTS_TIME_W-1:0] t;
    } tts_cnt_st_t;

    tts_cnt_st_t s_q;
    tts_cnt_st_t s_d;

    // Ripple-carry through the calendar fields
    always_comb begin
        logic [9:0] us;
        logic [9:0] ms;
        logic [5:0] sec;
        logic [5:0] mn;
        logic [4:0] hr;
        logic [8:0] day;
        s_d = s_q;
        us  = s_q.t[TTS_US_LSB +: TTS_US_W];
        ms  = s_q.t[TTS_MS_LSB +: TTS_MS_W];
        sec = s_q.t[TTS_SEC_LSB +: TTS_SEC_W];
        mn  = s_q.t[TTS_MIN_LSB +: TTS_MIN_W];
        hr  = s_q.t[TTS_HR_LSB +: TTS_HR_W];
        day = s_q.t[TTS_DAY_LSB +: TTS_DAY_W];
        if (load_i) begin
            s_d.t = load_val_i;
        end else if (tick_i) begin
            if (us != TTS_US_MAX) begin
                us = us + 10'h001;
            end else begin
                us = 10'h000;
                if (ms != TTS_MS_MAX) begin
                    ms = ms + 10'h001;
                end else begin
                    ms = 10'h000;
                    if (sec != TTS_SEC_MAX) begin
                        sec = sec + 6'h01;
                    end else begin
                        sec = 6'h00;
                        if (mn != TTS_MIN_MAX) begin
                            mn = mn + 6'h01;
                        end else begin
                            mn = 6'h00;
                            if (hr != TTS_HR_MAX) begin
                                hr = hr + 5'h01;
                            end else begin
                                hr  = 5'h00;
                                // Year wrap; leap days not tracked
                                day = (day >= TTS_DAY_MAX) ? TTS_DAY_MIN : day + 9'h001;
                            end
                        end
                    end
                end
            end
            s_d.t = {day, hr, mn, sec, ms, us};
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign time_o = s_q.t;

endmodule

// File: tts_stamper.sv
// Telemetry time stamper: source select, frame-sync capture, header writer
//
// Operation
// - Selector picks host counter or time code
// - Host load seeds the time counter
// - Counter runs alone on internal clock
// - Current time written into packet header
// - Decoded time code supplies stamping time
// - Sample time at last frame-sync bit
// - Holdover keeps time running after lock loss
// - No holdover freezes at last locked time
`timescale 1ns/10ps
module tts_stamper
    import tts_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk_sys_i,
    input  wire logic                  rst_i,
    // Configuration
    input  wire logic                  src_sel_i,
    input  wire logic [1:0]            code_fmt_i,
    input  wire logic                  holdover_en_i,
    // Host time load
    input  wire logic                  host_load_i,
    input  wire logic [TTS_TIME_W-1:0] host_time_i,
    // Time-code reader result (from a pin-side demodulator)
    input  wire logic                  code_lock_i,
    input  wire logic                  code_valid_i,
    input  wire logic [TTS_TIME_W-1:0] code_time_i,
    input  wire logic [1:0]            code_fmt_seen_i,
    // Frame sync
    input  wire logic                  sync_last_i,
    // Header output
    input  wire logic                  hdr_ready_i,
    output logic                       hdr_valid_o,
    output logic [TTS_HDR_W-1:0]       hdr_word_o,
    output logic                       hdr_last_o,
    // Status
    output logic [TTS_TIME_W-1:0]      time_now_o,
    output logic                       lock_o,
    output logic                       fmt_ok_o
);

    // State fields, all in one register:
    //   lock_sync  three flops on the asynchronous lock level
    //   locked     filtered lock, changes only when stages agree
    //   div        oscillator divider for the microsecond tick
    //   tick       one-cycle pulse that advances the counter
    //   stamp      time sampled at the last sync bit
    //   hst        header writer phase
    //   widx       index of the header word on the outputs
    //   pend       one sync remembered while a header is busy
    //   hvalid     header word valid towards the sink
    //   hword      header word on the outputs
    //   hlast      marks the third and final word
    //   now        running time, one cycle behind the counter
    //   fmt_ok     last decoded format matched the setting
    typedef struct packed {
        logic [2:0]            lock_sync;
        logic                  locked;
        logic [TTS_DIV_W-1:0]  div;
        logic                  tick;
        logic [TTS_TIME_W-1:0] stamp;
        tts_hdr_st_t           hst;
        logic [1:0]            widx;
        logic                  pend;
        logic                  hvalid;
        logic [TTS_HDR_W-1:0]  hword;
        logic                  hlast;
        logic [TTS_TIME_W-1:0] now;
        logic                  fmt_ok;
    } tts_st_t;

    tts_st_t s_q;
    tts_st_t s_d;

    logic                  cnt_load;
    logic [TTS_TIME_W-1:0] cnt_val;
    logic [TTS_TIME_W-1:0] cnt_time;
    logic                  code_fresh;
    logic                  lock_stable;

    // Time code accepted only while locked and in the chosen format
    assign code_fresh  = code_valid_i && s_q.locked && (code_fmt_seen_i == code_fmt_i);
    // Lock level filtered: second and third stages must agree
    assign lock_stable = (s_q.lock_sync[1] == s_q.lock_sync[2]);

    // A fresh code value replaces the running count outright; the
    // counter then interpolates between decoded times, which is what
    // keeps time moving if lock later drops with holdover enabled.
    // Counter seeding: host load, or locked time-code value
    always_comb begin
        cnt_load = 1'b0;
        cnt_val  = host_time_i;
        if (src_sel_i == TTS_SRC_HOST) begin
            cnt_load = host_load_i;
        end else if (code_fresh) begin
            cnt_load = 1'b1;
            cnt_val  = code_time_i;
        end
    end

    // Shared calendar counter
    tts_time_count u_count (
        .clk_sys_i  (clk_sys_i),
        .rst_i      (rst_i),
        .load_i     (cnt_load),
        .load_val_i (cnt_val),
        .tick_i     (s_q.tick),
        .time_o     (cnt_time)
    );

    // Next-state logic
    always_comb begin
        logic run;
        s_d      = s_q;
        run      = 1'b1;
        s_d.tick = 1'b0;

        // Lock loss takes effect three to four cycles late; a tick
        // in that gap is accepted as part of the last locked time.
        // Lock input from outside: three-stage synchroniser
        s_d.lock_sync = {s_q.lock_sync[1:0], code_lock_i};
        if (lock_stable) begin
            s_d.locked = s_q.lock_sync[2];
        end
        if (code_valid_i) begin
            s_d.fmt_ok = (code_fmt_seen_i == code_fmt_i);
        end

        if (src_sel_i == TTS_SRC_CODE && !s_q.locked) begin
            run = holdover_en_i;
        end

        // The divider runs even while the counter is frozen, so
        // holdover restarts on the oscillator phase it had; the
        // first tick after restart may come early by up to one us.
        // microsecond tick from oscillator
        if (s_q.div == TTS_DIV_LAST) begin
            s_d.div  = '0;
            s_d.tick = run;
        end else begin
            s_d.div = s_q.div + 7'h01;
        end
        s_d.now = cnt_time;

        // Header timing:
        //   edge 0: sync seen, stamp and first word taken together
        //   edge 1: first word valid, held until the sink takes it
        //   each accept moves to the next slice of the same stamp
        //   after the last accept one idle cycle passes
        // Only one sync is remembered while busy; a second one in
        // the same header is lost, acceptable since the sink takes
        // at most one header per frame.
        // Header writer: stamp taken at sync, sent as three words
        unique case (s_q.hst)
            TTS_HDR_IDLE: begin
                if (sync_last_i || s_q.pend) begin
                    s_d.stamp  = cnt_time;
                    s_d.pend   = 1'b0;
                    s_d.widx   = 2'h0;
                    s_d.hst    = TTS_HDR_SEND;
                    s_d.hvalid = 1'b1;
                    s_d.hword  = cnt_time[TTS_TIME_W-1 -: TTS_HDR_W];
                    s_d.hlast  = 1'b0;
                end
            end
            TTS_HDR_SEND: begin
                // A sync during the header is kept for next frame
                if (sync_last_i) begin
                    s_d.pend = 1'b1;
                end
                if (hdr_ready_i) begin
                    if (s_q.hlast) begin
                        s_d.hvalid = 1'b0;
                        s_d.hlast  = 1'b0;
                        s_d.hst    = TTS_HDR_DONE;
                    end else begin
                        s_d.widx  = s_q.widx + 2'h1;
                        s_d.hword = (s_q.widx == 2'h0) ? s_q.stamp[31:16] : s_q.stamp[15:0];
                        s_d.hlast = (s_q.widx == 2'(TTS_HDR_WORDS - 2));
                    end
                end
            end
            TTS_HDR_DONE: begin
                if (sync_last_i) begin
                    s_d.pend = 1'b1;
                end
                s_d.hst = TTS_HDR_IDLE;
            end
            default: begin
                s_d.hst = TTS_HDR_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flops
    assign hdr_valid_o = s_q.hvalid;
    assign hdr_word_o  = s_q.hword;
    assign hdr_last_o  = s_q.hlast;
    assign time_now_o  = s_q.now;
    assign lock_o      = s_q.locked;
    assign fmt_ok_o    = s_q.fmt_ok;

endmodule

// File: tts_stamper_monitor.sv
// Port checker for the telemetry time stamper
`timescale 1ns/10ps
module tts_stamper_monitor
    import tts_pkg::*;
(
    input wire logic                  clk_sys_i,
    input wire logic                  rst_i,
    input wire logic                  src_sel_i,
    input wire logic [1:0]            code_fmt_i,
    input wire logic                  holdover_en_i,
    input wire logic                  host_load_i,
    input wire logic [TTS_TIME_W-1:0] host_time_i,
    input wire logic                  code_lock_i,
    input wire logic                  code_valid_i,
    input wire logic [TTS_TIME_W-1:0] code_time_i,
    input wire logic [1:0]            code_fmt_seen_i,
    input wire logic                  sync_last_i,
    input wire logic                  hdr_ready_i,
    input wire logic                  hdr_valid_o,
    input wire logic [TTS_HDR_W-1:0]  hdr_word_o,
    input wire logic                  hdr_last_o,
    input wire logic [TTS_TIME_W-1:0] time_now_o,
    input wire logic                  lock_o,
    input wire logic                  fmt_ok_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    logic [7:0]            run_q;
    logic [1:0]            wc_q;
    logic [TTS_TIME_W-1:0] tn_q;
    // Words accepted and cycles since the time last moved; a stuck counter shows here
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            run_q <= 8'h00;
            wc_q <= 2'h0;
            tn_q <= '0;
        end else begin
            tn_q <= time_now_o;
            run_q <= (src_sel_i && !holdover_en_i && !lock_o) || time_now_o != tn_q ? 8'h00 : run_q + 8'h01;
            if (hdr_valid_o && hdr_ready_i)
                wc_q <= hdr_last_o ? 2'h0 : wc_q + 2'h1;
        end
    end
    sequence s_start;
        !hdr_valid_o && !$past(hdr_valid_o) && sync_last_i;
    endsequence
    sequence s_code;
        src_sel_i && lock_o && code_valid_i && code_fmt_seen_i == code_fmt_i;
    endsequence
    AST_HDR_START: assert property (s_start |=> hdr_valid_o && !hdr_last_o && wc_q == 2'h0)
        else $error("header did not start after sync");
    AST_HDR_HOLD: assert property (hdr_valid_o && !hdr_ready_i |=> hdr_valid_o && $stable(hdr_word_o))
        else $error("header word moved while stalled");
    AST_HDR_LAST: assert property (hdr_valid_o |-> hdr_last_o == (wc_q == 2'h2))
        else $error("last flag on wrong word");
    AST_HDR_END: assert property (hdr_valid_o && hdr_ready_i && hdr_last_o |=> !hdr_valid_o)
        else $error("header valid after last word");
    AST_HOST_LOAD: assert property (host_load_i && !src_sel_i |=> ##1 time_now_o == $past(host_time_i, 2))
        else $error("host time not loaded");
    AST_CODE_LOAD: assert property (s_code |=> ##1 time_now_o == $past(code_time_i, 2))
        else $error("code time not taken");
    AST_FMT_OK: assert property (code_valid_i |=> fmt_ok_o == $past(code_fmt_seen_i == code_fmt_i))
        else $error("format flag wrong");
    AST_FREEZE: assert property ((src_sel_i && !lock_o && !holdover_en_i)[*3] |=> $stable(time_now_o))
        else $error("time moved without lock");
    AST_RUN: assert property (run_q < 8'd92)
        else $error("time stopped running");
    AST_LOCK: assert property ($stable(code_lock_i)[*5] |-> lock_o == code_lock_i)
        else $error("lock status lags");
endmodule

bind tts_stamper tts_stamper_monitor tts_stamper_monitor_inst (.*);

// File: tts_code_src.sv
// Behavioural time-code source feeding the stamper's code inputs
`timescale 1ns/10ps
module tts_code_src
    import tts_pkg::*;
(
    input  wire logic                  clk_sys_i,
    input  wire logic                  lock_en_i,
    input  wire logic [1:0]            fmt_i,
    output logic                       code_lock_o,
    output logic                       code_valid_o,
    output logic [TTS_TIME_W-1:0]      code_time_o,
    output logic [1:0]                 code_fmt_o,
    output logic [TTS_TIME_W-1:0]      last_time_o
);
    logic [5:0] gap_q = 6'h00;
    initial begin
        code_lock_o = 1'b0;
        code_valid_o = 1'b0;
        code_fmt_o = 2'h0;
        code_time_o = '0;
        last_time_o = 48'h0020_0000_0000;
    end
    // One decoded time every 64 cycles; bus shows junk between pulses
    always @(negedge clk_sys_i) begin
        gap_q <= gap_q + 6'h01;
        code_lock_o <= lock_en_i;
        code_fmt_o <= fmt_i;
        code_valid_o <= lock_en_i && gap_q == 6'h3F;
        if (lock_en_i && gap_q == 6'h3F) begin
            last_time_o <= last_time_o + 48'h400;
            code_time_o <= last_time_o + 48'h400;
        end else begin
            code_time_o <= ~last_time_o;
        end
    end
endmodule

// File: tts_stamper_tb.sv
// Self-checking testbench for the telemetry time stamper
`timescale 1ns/10ps
module tts_stamper_tb;
    import tts_pkg::*;
    logic clk_sys_i, rst_i, src_sel_i, holdover_en_i, host_load_i, sync_last_i, hdr_ready_i, lock_en;
    logic [1:0] code_fmt_i, pfmt, code_fmt_seen_i;
    logic [47:0] host_time_i, code_time_i, time_now_o, ptime, f;
    logic code_lock_i, code_valid_i, hdr_valid_o, hdr_last_o, lock_o, fmt_ok_o;
    logic [15:0] hdr_word_o;
    int errors = 0;
    int n_compared = 0;
    tts_stamper tts_stamper_inst (.*);
    tts_code_src tts_code_src_inst (.clk_sys_i(clk_sys_i), .lock_en_i(lock_en), .fmt_i(pfmt),
        .code_lock_o(code_lock_i), .code_valid_o(code_valid_i), .code_time_o(code_time_i),
        .code_fmt_o(code_fmt_seen_i), .last_time_o(ptime));
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got, input bit same = 1);
        n_compared++;
        if ((got === exp) != same) begin
            errors++;
            $display("[FAIL] %s expected %s%h seen %h", what, same ? "" : "not ", exp, got);
        end
    endtask
    task automatic wait_valid();
        repeat (100) begin
            @(posedge clk_sys_i);
            if (code_valid_i === 1'b1)
                return;
        end
        check("code pulse", 1, 0);
    endtask
    // Sync pulse, then three stalled header words
    task automatic read_hdr(output logic [47:0] v);
        sync_last_i = 1'b1;
        cyc(1);
        sync_last_i = 1'b0;
        for (int i = 0; i < 3; i++) begin
            cyc(2);
            hdr_ready_i = 1'b1;
            check("hdr flags", {1'b1, i == 2}, {hdr_valid_o, hdr_last_o});
            v = {v[31:0], hdr_word_o};
            cyc(1);
            hdr_ready_i = 1'b0;
        end
    endtask
    task automatic t_host();
        logic [47:0] v;
        host_time_i = 48'h0045_0000_0000;
        host_load_i = 1'b1;
        cyc(1);
        host_load_i = 1'b0;
        cyc(2);
        check("host load", host_time_i, time_now_o);
        cyc(300);
        check("host run", host_time_i, time_now_o, 0);
        read_hdr(v);
        check("host hdr", host_time_i[47:16], v[47:16]);
        $display("host test done");
    endtask
    task automatic t_code();
        src_sel_i = 1'b1;
        for (int k = 0; k < 8; k++) begin
            code_fmt_i = 2'(k / 2);
            pfmt = 2'(k / 2) ^ 2'(k % 2);
            wait_valid();
            cyc(3);
            check("fmt ok", k % 2 == 0, fmt_ok_o);
            check("lock held", 1, lock_o);
            check("code time", ptime, time_now_o, k % 2 == 0);
        end
        $display("code test done");
    endtask
    task automatic t_freeze();
        logic [47:0] v;
        pfmt = code_fmt_i;
        wait_valid();
        cyc(1);
        lock_en = 1'b0;
        cyc(12);
        f = time_now_o;
        check("lock lost", 0, lock_o);
        check("frozen", ptime[47:10], f[47:10]);
        host_time_i = 48'h0081_0000_0000;
        host_load_i = 1'b1;
        cyc(1);
        host_load_i = 1'b0;
        cyc(200);
        check("still frozen", f, time_now_o);
        read_hdr(v);
        check("frozen hdr", f, v);
        holdover_en_i = 1'b1;
        cyc(200);
        check("holdover", f, time_now_o, 0);
        $display("lock loss test done");
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Free-running 200 MHz clock
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    // Hang guard, far beyond the roughly 1300 cycles needed
    initial begin
        #100000;
        errors++;
        complete_run();
    end
    // Main sequence
    initial begin
        {rst_i, src_sel_i, holdover_en_i, host_load_i, sync_last_i, hdr_ready_i, lock_en} = 7'h41;
        {code_fmt_i, pfmt, host_time_i} = '0;
        cyc(8);
        rst_i = 1'b0;
        cyc(2);
        t_host();
        t_code();
        t_freeze();
        complete_run();
    end
endmodule
